//--- logic/sepr_slave.sv
// two-wire slave read path in front of a 128 x 8 word array
// assumes an external pull-up resolves the open-drain data line
`timescale 1ns/10ps
module sepr_slave #(
    parameter int DEPTH = sepr_pkg::SEPR_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [2:0] chip_select_pins,
    input  wire logic       load_en,
    input  wire logic [6:0] load_addr,
    input  wire logic [7:0] load_data,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            busy
);
    import sepr_pkg::*;

    typedef enum {ST_IDLE, ST_DEVADDR, ST_ACK_DEV, ST_WORDADDR, ST_ACK_WORD,
                  ST_SEND, ST_ACK_IN, ST_WAIT} sepr_state_type;

    logic [7:0]             mem [DEPTH];   // word array, loaded by side port
    logic                   scl_s;         // synchronised clock pin
    logic                   sda_s;         // synchronised data pin
    logic                   scl_q;         // previous clock sample
    logic                   sda_q;         // previous data sample
    sepr_state_type         state;
    sepr_state_type         next_state;
    logic [3:0]             bitcnt;        // bit within a byte
    logic [3:0]             next_bitcnt;
    logic [7:0]             shreg;         // in/out shift register
    logic [7:0]             next_shreg;
    logic [SEPR_ADDR_W-1:0] ptr;           // word address counter
    logic [SEPR_ADDR_W-1:0] next_ptr;
    logic                   drive_low;     // pulling the line low
    logic                   next_drive_low;
    logic                   next_busy;
    logic [2:0]             cs_s;          // synchronised chip-select pins

    // pin synchronisers
    sepr_sync u_sync_scl (.clk_sys(clk_sys), .nrst(nrst), .din(scl_in), .dout(scl_s));
    sepr_sync u_sync_sda (.clk_sys(clk_sys), .nrst(nrst), .din(sda_in), .dout(sda_s));

    // select pins may be driven at run time, so they pass two flops as well;
    // a change takes effect at the next address compare, once it has passed the two flops
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_cs_sync
            sepr_sync u_sync_cs (
                .clk_sys (clk_sys),
                .nrst    (nrst),
                .din     (chip_select_pins[g]),
                .dout    (cs_s[g])
            );
        end
    endgenerate

    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // address compare, used for both directions
    function automatic logic addr_match(input logic [7:0] b, input logic [2:0] cs);
        addr_match = (b[7:4] == SEPR_DEV_TYPE) && (b[3:1] == cs);
    endfunction

    // array write port; write path proper is outside this block
    always_ff @(posedge clk_sys) begin
        if (load_en) begin
            mem[load_addr] <= load_data;
        end
    end

    // next-state logic of the protocol engine
    always_comb begin
        next_state     = state;
        next_bitcnt    = bitcnt;
        next_shreg     = shreg;
        next_ptr       = ptr;
        next_drive_low = drive_low;
        if (stop_det) begin
            next_state     = ST_IDLE;
            next_drive_low = 1'b0;
        end else if (start_det) begin
            next_state     = ST_DEVADDR;
            next_bitcnt    = '0;
            next_drive_low = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_WAIT: begin
                    // released line; only start or stop leaves
                    next_drive_low = 1'b0;
                end
                ST_DEVADDR, ST_WORDADDR: begin
                    if (scl_rise) begin
                        next_shreg  = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == SEPR_BIT_ACK) begin
                        next_bitcnt = '0;
                        if (state == ST_WORDADDR) begin
                            next_ptr       = shreg[SEPR_ADDR_W-1:0];
                            next_drive_low = 1'b1;
                            next_state     = ST_ACK_WORD;
                        end else if (addr_match(shreg, cs_s)) begin
                            next_drive_low = 1'b1;
                            next_state     = ST_ACK_DEV;
                        end else begin
                            next_state = ST_WAIT;                    // not addressed
                        end
                    end
                end
                ST_ACK_DEV: begin
                    if (scl_fall) begin
                        if (shreg[0]) begin
                            next_shreg     = {mem[ptr][6:0], 1'b0};
                            next_drive_low = ~mem[ptr][7];
                            next_ptr       = ptr + 1'b1;
                            next_state     = ST_SEND;
                            next_bitcnt    = '0;
                        end else begin
                            next_drive_low = 1'b0;
                            next_state     = ST_WORDADDR;
                        end
                    end
                end
                ST_ACK_WORD: begin
                    // bytes after the word address belong to the write path
                    if (scl_fall) begin
                        next_drive_low = 1'b0;
                        next_state     = ST_WAIT;
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bitcnt == SEPR_BIT_LAST - 4'h1) begin
                            next_drive_low = ~shreg[7];
                            next_bitcnt    = SEPR_BIT_LAST;
                        end else if (bitcnt == SEPR_BIT_LAST) begin
                            next_drive_low = 1'b0;
                            next_state     = ST_ACK_IN;
                        end else begin
                            next_drive_low = ~shreg[7];
                            next_shreg     = {shreg[6:0], 1'b0};
                            next_bitcnt    = bitcnt + 4'h1;
                        end
                    end
                end
                ST_ACK_IN: begin
                    // ninth slot is sampled, never ignored
                    if (scl_rise) begin
                        next_bitcnt = sda_s ? SEPR_BIT_ACK : 4'h0;
                    end
                    if (scl_fall) begin
                        if (bitcnt == 4'h0) begin
                            next_shreg     = {mem[ptr][6:0], 1'b0};
                            next_drive_low = ~mem[ptr][7];
                            next_ptr       = ptr + 1'b1;
                            next_state     = ST_SEND;
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
        next_busy = (next_state != ST_IDLE);
    end

    // state registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            bitcnt    <= '0;
            shreg     <= '0;
            ptr       <= SEPR_PTR_RST;
            drive_low <= 1'b0;
            busy      <= 1'b0;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
        end else begin
            state     <= next_state;
            bitcnt    <= next_bitcnt;
            shreg     <= next_shreg;
            ptr       <= next_ptr;
            drive_low <= next_drive_low;
            busy      <= next_busy;
            scl_q     <= scl_s;
            sda_q     <= sda_s;
        end
    end

    // open-drain pin: only low is ever driven
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe  <= next_drive_low;
            sda_out <= 1'b0;
        end
    end

    // idle with the line released, one cycle apart
    sequence idle_release_s;
        (state == ST_IDLE) ##1 !sda_oe;
    endsequence

    // parked in wait with the line released, one cycle apart
    sequence wait_release_s;
        (state == ST_WAIT) ##1 !sda_oe;
    endsequence

    // stop always returns to idle with the line released
    stop_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        stop_det |=> idle_release_s)
        else $error("stop did not release bus");

    // counter advances by one per byte sent, wrapping
    ptr_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (next_state == ST_SEND && state != ST_SEND) |=> ptr == $past(ptr) + 7'h01)
        else $error("counter did not advance");

    // line released for the whole acknowledge slot of a read; the next byte's
    // first bit may only appear once the state has left the slot
    ack_release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_ACK_IN) |-> !sda_oe)
        else $error("line driven in master ack slot");

    // pin only changes while clock is low
    change_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(sda_oe) && !$past(stop_det || start_det) |-> !scl_q || !$past(scl_s))
        else $error("data changed with clock high");

    // word address load keeps seven bits
    word_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_WORDADDR && next_state == ST_ACK_WORD)
        |=> ptr == $past(shreg[6:0]))
        else $error("word address not loaded");

    // nack ends transmission
    nack_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_ACK_IN && bitcnt == SEPR_BIT_ACK && scl_fall && !start_det && !stop_det)
        |=> wait_release_s)
        else $error("sent after nack");

    // mismatched address never acknowledged
    no_match_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_DEVADDR && bitcnt == SEPR_BIT_ACK && scl_fall && !start_det && !stop_det
         && !addr_match(shreg, cs_s)) |=> state == ST_WAIT)
        else $error("acked wrong address");

    // start always reopens address reception
    start_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (start_det && !stop_det) |=> state == ST_DEVADDR && bitcnt == 4'h0)
        else $error("start not honoured");

    // read address acks then sends
    read_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_ACK_DEV && shreg[0] && scl_fall && !start_det && !stop_det)
        |=> state == ST_SEND)
        else $error("read not started");
endmodule

//--- logic/sepr_pkg.sv
// constants shared by the serial memory read-path slave
// assumes a single system clock domain that samples the two-wire pins
package sepr_pkg;
    localparam int          SEPR_ADDR_W    = 7;        // word address width
    localparam int          SEPR_DEPTH     = 128;      // words in the array
    localparam logic [3:0]  SEPR_DEV_TYPE  = 4'h0;     // device-type field, value arbitrary
    localparam logic [6:0]  SEPR_PTR_RST   = 7'h00;    // counter value after reset
    localparam logic [3:0]  SEPR_BIT_LAST  = 4'h7;     // bit index of last data bit
    localparam logic [3:0]  SEPR_BIT_ACK   = 4'h8;     // bit index of the ninth slot
    localparam int          SEPR_SYNC_LEN  = 2;        // pin synchroniser depth
endpackage

//--- logic/sepr_sync.sv
// two-flop synchroniser for the serial clock, data and chip-select pins
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/10ps
module sepr_sync (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    import sepr_pkg::*;
    logic [SEPR_SYNC_LEN-1:0] stage; // stage[0] feeds only stage[1]

    // shift chain; idle bus level is high
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage <= '1;
        end else begin
            stage <= {stage[SEPR_SYNC_LEN-2:0], din};
        end
    end
    assign dout = stage[SEPR_SYNC_LEN-1];
endmodule

//--- tb/sepr_master.sv
// behavioural two-wire bus master facing the read-path slave
// assumes the bench calls its tasks in sequence; the line has a pull-up
`timescale 1ns/10ps
module sepr_master (
    input  wire logic sda_oe,
    output logic      scl,
    output wire logic sda_line
);
    logic m_low;                               // master pulls data low
    // wired-and line: released level is the pull-up
    assign sda_line = !(sda_oe || m_low);
    initial begin
        scl   = 1'b1;                          // link clock idles high between frames
        m_low = 1'b0;
    end
    // start or repeated start; data falls while clock high
    task automatic start();
        #16 m_low = 1'b0;
        #16 scl = 1'b1;
        #32 m_low = 1'b1;
        #32 scl = 1'b0;
    endtask
    // stop after a released slot; data rises while clock high
    task automatic stop();
        #16 m_low = 1'b1;
        #16 scl = 1'b1;
        #32 m_low = 1'b0;
        #32;
    endtask
    // one clock; data set well after the fall so the slave never sees it move while high
    task automatic bitc(input logic lo, output logic got);
        #16 m_low = lo;
        #16 scl = 1'b1;
        #16 got = sda_line;
        #16 scl = 1'b0;
    endtask
    // send a byte msb first, then sample the ninth slot
    task automatic send(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitc(!b[i], g);
        end
        bitc(1'b0, g);
        ack = !g;
    endtask
    // take a byte; pull low in the ninth slot only when more is wanted
    task automatic recv(input logic more, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitc(1'b0, b[i]);
        end
        bitc(more, g);
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the serial memory read-path slave
// assumes sepr_pkg and sepr_slave are compiled first
`timescale 1ns/10ps
module tb_top;
    import sepr_pkg::*;
    logic       clk_sys;                       // 200 MHz system clock
    logic       nrst;                          // async reset, active low
    logic [2:0] chip_select_pins;              // slave address select bits
    logic       load_en;                       // array preload strobe
    logic [6:0] load_addr;
    logic [7:0] load_data;
    logic       sda_out;
    logic       sda_oe;
    logic       busy;
    logic       scl;
    logic       sda_line;                      // resolved data line
    int         errors;
    int         checked;
    logic [2:0] cs;                            // select value the master addresses
    initial clk_sys = 1'b0;
    always #2.5 clk_sys = !clk_sys;
    sepr_slave dut_u (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
        .chip_select_pins(chip_select_pins), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
    sepr_master bus_u (.sda_oe(sda_oe), .scl(scl), .sda_line(sda_line));
    // array contents, distinct per word
    function automatic logic [7:0] val(input int a);
        return 8'(a * 37) ^ 8'h5c;
    endfunction
    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic test_done();
        $display("checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // random read, optionally continued; words counted from word[6:0]
    task automatic rand_read(input logic [7:0] word, input int n);
        logic       a0, a1, a2;
        logic [7:0] d;
        bus_u.start();
        bus_u.send({SEPR_DEV_TYPE, cs, 1'b0}, a0);
        bus_u.send(word, a1);
        bus_u.start();
        bus_u.send({SEPR_DEV_TYPE, cs, 1'b1}, a2);
        checked++;
        if ({a0, a1, a2} !== 3'b111) fail("address phase not acknowledged");
        for (int i = 0; i < n; i++) begin
            bus_u.recv(i < n - 1, d);
            checked++;
            if (d !== val((word[6:0] + i) % 128)) fail("read data wrong");
        end
        bus_u.stop();
    endtask
    // current-address read of one word
    task automatic cur_read(input int exp_addr);
        logic       a;
        logic [7:0] d;
        bus_u.start();
        bus_u.send({SEPR_DEV_TYPE, cs, 1'b1}, a);
        checked++;
        if (busy !== 1'b1 || sda_out !== 1'b0) fail("pin state wrong in transfer");
        bus_u.recv(1'b0, d);
        bus_u.stop();
        checked++;
        if (a !== 1'b1 || d !== val(exp_addr)) fail("current read wrong");
    endtask
    // nack ends the stream: the next clocked byte must see a released line
    task automatic nack_release();
        logic       a;
        logic [7:0] d;
        bus_u.start();
        bus_u.send({SEPR_DEV_TYPE, cs, 1'b1}, a);
        bus_u.recv(1'b0, d);
        checked++;
        if (d !== val(2)) fail("first byte wrong");
        bus_u.recv(1'b0, d);
        checked++;
        if (d !== 8'hff) fail("line driven after nack");
        bus_u.stop();
        for (int i = 0; i <= 20 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            if (i == 20) begin
                fail("busy stuck after stop");
                test_done();
            end
        end
    endtask
    // wrong select bits get no acknowledge; right ones still work
    task automatic mismatch();
        logic a;
        @(posedge clk_sys);
        chip_select_pins <= 3'b101;
        cs = 3'b010;
        bus_u.start();
        bus_u.send({SEPR_DEV_TYPE, cs, 1'b1}, a);
        bus_u.stop();
        checked++;
        if (a !== 1'b0) fail("foreign address acknowledged");
        cs = 3'b101;
        cur_read(3);
    endtask
    // main sequence
    initial begin
        nrst = 1'b0;
        chip_select_pins = 3'b011;
        cs = 3'b011;
        load_en = 1'b0;
        load_addr = 7'h00;
        load_data = 8'h00;
        errors = 0;
        checked = 0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 0; a < 128; a++) begin
            @(posedge clk_sys);
            load_en <= 1'b1;
            load_addr <= 7'(a);
            load_data <= val(a);
        end
        @(posedge clk_sys);
        load_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rand_read(8'h85, 1);
        cur_read(6);
        rand_read(8'h7e, 4);
        nack_release();
        mismatch();
        test_done();
    end
endmodule
